/* mexp_pkg.sv */
// Shared constants, types and state layout for the math expression unit
// Operation
// [RULE_01] Unit activates on enable rising edge
// [RULE_02] Zero divide or overflow saturates, underflow floors
// [RULE_03] Always four operands and three operators
// [RULE_04] Operator selects add, subtract, multiply, divide
// [RULE_05] Round group, then square group, then plain
// [RULE_06] Result rounded to nearest integer
// [RULE_07] Disabled: zero, or hold last value
// [RULE_08] Operands clamped to signed 16-bit range
// [RULE_09] Flags rewritten at end of each execution
// [RULE_10] Error output follows selected flag source
// [RULE_11] Detector activates on its enable rising edge
// [RULE_12] Detector reset clears error output
// [RULE_13] Auto-clear clears output before each execution
// [RULE_14] Without auto-clear, error output latches
// [RULE_15] Same scan if unit runs first
// [RULE_16] No referenced unit keeps error low
// [RULE_17] Decimal places only affect display
// [RULE_18] Wide intermediates detect overflow before saturation
package mexp_pkg;
  localparam int MEXP_WIDE = 48;
  localparam int MEXP_FRAC = 8;
  localparam int MEXP_ADDR_W = 8;
  localparam int MEXP_NOPND = 4;
  localparam int MEXP_NOPER = 3;
  localparam int MEXP_CTRL_W = 11;
  localparam int MEXP_OPCFG_W = 12;
  localparam int MEXP_IRQ_W = 2;
  localparam int MEXP_IRQ_DONE = 0;
  localparam int MEXP_IRQ_ERR = 1;
  localparam int MEXP_FLAG_DZ = 0;
  localparam int MEXP_FLAG_OF = 1;
  localparam int MEXP_FLAG_ERR = 2;
  localparam int MEXP_FLAG_BUSY = 3;
  localparam int MEXP_FLAG_UACT = 4;
  localparam int MEXP_FLAG_DACT = 5;
  localparam int MEXP_SCAN_GO = 0;
  localparam logic [MEXP_ADDR_W-1:0] MEXP_REG_CTRL = 8'h00;
  localparam logic [MEXP_ADDR_W-1:0] MEXP_REG_OPS = 8'h04;
  localparam logic [MEXP_ADDR_W-1:0] MEXP_REG_OPND0 = 8'h08;
  localparam logic [MEXP_ADDR_W-1:0] MEXP_REG_OPND1 = 8'h0c;
  localparam logic [MEXP_ADDR_W-1:0] MEXP_REG_OPND2 = 8'h10;
  localparam logic [MEXP_ADDR_W-1:0] MEXP_REG_OPND3 = 8'h14;
  localparam logic [MEXP_ADDR_W-1:0] MEXP_REG_SCAN = 8'h18;
  localparam logic [MEXP_ADDR_W-1:0] MEXP_REG_RESULT = 8'h1c;
  localparam logic [MEXP_ADDR_W-1:0] MEXP_REG_FLAGS = 8'h20;
  localparam logic [MEXP_ADDR_W-1:0] MEXP_REG_IRQ_STAT = 8'h24;
  localparam logic [MEXP_ADDR_W-1:0] MEXP_REG_IRQ_MASK = 8'h28;
  localparam logic [15:0] MEXP_SAT_MAX = 16'h7fff;
  localparam logic [15:0] MEXP_SAT_MIN = 16'h8000;
  localparam logic [MEXP_WIDE-1:0] MEXP_HALF = {{(MEXP_WIDE-MEXP_FRAC){1'b0}}, 1'b1, {(MEXP_FRAC-1){1'b0}}};
  localparam logic [MEXP_WIDE-1:0] MEXP_WMAX16 = {{(MEXP_WIDE-15){1'b0}}, {15{1'b1}}};
  localparam logic [MEXP_WIDE-1:0] MEXP_WMIN16 = {{(MEXP_WIDE-15){1'b1}}, {15{1'b0}}};
  localparam logic [1:0] MEXP_STEP_LAST = 2'h2;

  typedef enum logic [1:0] {
    MEXP_OP_ADD = 2'h0,
    MEXP_OP_SUB = 2'h1,
    MEXP_OP_MUL = 2'h2,
    MEXP_OP_DIV = 2'h3
  } mexp_op_t;

  typedef enum logic [1:0] {
    MEXP_PRI_NONE = 2'h0,
    MEXP_PRI_SQUARE = 2'h1,
    MEXP_PRI_ROUND = 2'h2,
    MEXP_PRI_RSVD = 2'h3
  } mexp_pri_t;

  typedef enum logic [1:0] {
    MEXP_SEL_DZ = 2'h0,
    MEXP_SEL_OF = 2'h1,
    MEXP_SEL_BOTH = 2'h2,
    MEXP_SEL_RSVD = 2'h3
  } mexp_sel_t;

  typedef enum logic [2:0] {
    MEXP_ST_IDLE = 3'b001,
    MEXP_ST_EVAL = 3'b010,
    MEXP_ST_DONE = 3'b100
  } mexp_fsm_t;

  typedef struct packed {
    logic det_rst;
    logic [1:0] decimals;
    logic det_after;
    logic ref_valid;
    mexp_sel_t sel;
    logic auto_clear;
    logic det_en;
    logic hold;
    logic enable;
  } mexp_ctrl_t;

  typedef struct packed {
    mexp_pri_t [MEXP_NOPER-1:0] pri;
    mexp_op_t [MEXP_NOPER-1:0] op;
  } mexp_opcfg_t;

  typedef struct packed {
    logic [3:0] be;
    logic [31:0] wdata;
    logic [MEXP_ADDR_W-1:0] addr;
    logic write;
    logic read;
  } mexp_avs_req_t;

  typedef struct packed {
    mexp_fsm_t fsm;
    logic [1:0] step;
    logic [MEXP_NOPND-1:0][MEXP_WIDE-1:0] vals;
    mexp_opcfg_t cur;
    logic dz;
    logic ovp;
    logic ovn;
    mexp_ctrl_t ctrl;
    mexp_opcfg_t opcfg;
    logic [MEXP_NOPND-1:0][31:0] opnd;
    logic [MEXP_IRQ_W-1:0] irq_stat;
    logic [MEXP_IRQ_W-1:0] irq_mask;
    logic [15:0] result;
    logic div_zero;
    logic overflow;
    logic error_out;
    logic en_q;
    logic det_en_q;
    logic unit_active;
    logic det_active;
    logic irq;
    logic waitreq;
    logic [31:0] rdata;
  } mexp_state_t;
endpackage

/* mexp_binop.sv */
// One wide fixed-point arithmetic step with saturation
`timescale 1ns/1ps
module mexp_binop (
  input wire logic [mexp_pkg::MEXP_WIDE-1:0] a, // Left operand, fixed point
  input wire logic [mexp_pkg::MEXP_WIDE-1:0] b, // Right operand, fixed point
  input wire mexp_pkg::mexp_op_t op, // Operation code
  output logic [mexp_pkg::MEXP_WIDE-1:0] y, // Saturated result
  output logic dz, // Divisor was zero
  output logic ovp, // Positive overflow
  output logic ovn // Negative overflow
);
  localparam int W = mexp_pkg::MEXP_WIDE;
  localparam int F = mexp_pkg::MEXP_FRAC;
  localparam logic [2*W-1:0] WMAX = {{(W+1){1'b0}}, {(W-1){1'b1}}};
  logic signed [2*W-1:0] ax;
  logic signed [2*W-1:0] bx;
  logic signed [2*W-1:0] wide;

  assign ax = {{W{a[W-1]}}, a};
  assign bx = {{W{b[W-1]}}, b};

  always_comb begin
    dz = 1'b0;
    ovp = 1'b0;
    ovn = 1'b0;
    wide = '0;
    // [RULE_04] Operator decode
    unique case (op)
      mexp_pkg::MEXP_OP_ADD: wide = ax + bx;
      mexp_pkg::MEXP_OP_SUB: wide = ax - bx;
      mexp_pkg::MEXP_OP_MUL: wide = (ax * bx) >>> F;
      mexp_pkg::MEXP_OP_DIV: begin
        if (b == '0) begin
          dz = 1'b1;
          wide = $signed(WMAX);
        end else begin
          wide = (ax <<< F) / bx;
        end
      end
    endcase
    // [RULE_18] Double width result checked before narrowing
    if (!dz && wide > $signed(WMAX)) begin
      ovp = 1'b1;
      y = WMAX[W-1:0];
    end else if (wide < -$signed(WMAX)) begin
      ovn = 1'b1;
      y = -WMAX[W-1:0];
    end else begin
      y = wide[W-1:0];
    end
  end
endmodule

/* mexp_unit.sv */
// Math expression unit with error detection and Avalon-MM register slave
//
// The Avalon-MM slave port and the address map were decided locally.
`timescale 1ns/1ps
module mexp_unit (
  input wire logic clk, // 40 MHz clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic [mexp_pkg::MEXP_ADDR_W-1:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Write byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall, low for one accept cycle
  output logic [15:0] result_out, // Signed expression result
  output logic div_zero_flag, // Last execution divided by zero
  output logic overflow_flag, // Last execution overflowed
  output logic error_out, // Error detector output
  output logic irq // Level interrupt
);
  localparam int W = mexp_pkg::MEXP_WIDE;
  localparam int F = mexp_pkg::MEXP_FRAC;

  mexp_pkg::mexp_state_t s;
  mexp_pkg::mexp_state_t n;
  mexp_pkg::mexp_avs_req_t req;
  logic [W-1:0] op_a;
  logic [W-1:0] op_b;
  logic [W-1:0] op_y;
  logic op_dz;
  logic op_ovp;
  logic op_ovn;
  logic [1:0] pick;
  logic accept;

  assign req = '{be: avs_byteenable, wdata: avs_writedata, addr: avs_address, write: avs_write, read: avs_read};
  assign accept = (req.read || req.write) && !s.waitreq;

  function automatic logic [1:0] rank(input mexp_pkg::mexp_pri_t p);
    unique case (p)
      mexp_pkg::MEXP_PRI_ROUND: rank = 2'h2;
      mexp_pkg::MEXP_PRI_SQUARE: rank = 2'h1;
      default: rank = 2'h0;
    endcase
  endfunction

  // [RULE_08] Operand limited to signed 16-bit range
  function automatic logic [15:0] clamp16(input logic [31:0] v);
    if ($signed(v) > $signed({16'h0000, mexp_pkg::MEXP_SAT_MAX})) begin
      clamp16 = mexp_pkg::MEXP_SAT_MAX;
    end else if ($signed(v) < $signed({16'hffff, mexp_pkg::MEXP_SAT_MIN})) begin
      clamp16 = mexp_pkg::MEXP_SAT_MIN;
    end else begin
      clamp16 = v[15:0];
    end
  endfunction

  function automatic logic [W-1:0] widen(input logic [15:0] v);
    widen = {{(W-16-F){v[15]}}, v, {F{1'b0}}};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  // [RULE_10] Source select, auto-clear or latch
  function automatic logic det_eval(input logic prev, input mexp_pkg::mexp_ctrl_t c, input logic dz, input logic of);
    logic hit;
    hit = 1'b0;
    unique case (c.sel)
      mexp_pkg::MEXP_SEL_DZ: hit = dz;
      mexp_pkg::MEXP_SEL_OF: hit = of;
      mexp_pkg::MEXP_SEL_BOTH: hit = dz | of;
      default: hit = 1'b0;
    endcase
    // [RULE_13] Auto-clear drops the old value first
    // [RULE_14] Otherwise the old value is kept
    det_eval = (c.auto_clear ? 1'b0 : prev) | hit;
  endfunction

  // [RULE_05] Highest bracket rank wins, leftmost on a tie
  always_comb begin
    int best;
    int nrem;
    best = 0;
    nrem = mexp_pkg::MEXP_NOPER - int'(s.step);
    for (int i = 1; i < mexp_pkg::MEXP_NOPER; i++) begin
      if (i < nrem && rank(s.cur.pri[i]) > rank(s.cur.pri[best])) begin
        best = i;
      end
    end
    pick = best[1:0];
  end

  assign op_a = s.vals[pick];
  assign op_b = s.vals[pick + 2'h1];

  mexp_binop u_binop (
    .a(op_a),
    .b(op_b),
    .op(s.cur.op[pick]),
    .y(op_y),
    .dz(op_dz),
    .ovp(op_ovp),
    .ovn(op_ovn)
  );

  always_comb begin
    logic [31:0] wv;
    logic scan_req;
    logic scan_go;
    logic unit_run;
    logic [W-1:0] mag;
    logic [W-1:0] rq;
    logic range_ovf;
    logic [mexp_pkg::MEXP_IRQ_W-1:0] ev;
    wv = '0;
    scan_req = 1'b0;
    scan_go = 1'b0;
    unit_run = 1'b0;
    mag = '0;
    rq = '0;
    range_ovf = 1'b0;
    ev = '0;
    n = s;

    // Bus slave: one wait cycle, then a one-cycle accept
    n.waitreq = 1'b1;
    if ((req.read || req.write) && s.waitreq) begin
      n.waitreq = 1'b0;
      unique case (req.addr)
        mexp_pkg::MEXP_REG_CTRL: n.rdata = 32'(s.ctrl);
        mexp_pkg::MEXP_REG_OPS: n.rdata = 32'(s.opcfg);
        mexp_pkg::MEXP_REG_OPND0: n.rdata = s.opnd[0];
        mexp_pkg::MEXP_REG_OPND1: n.rdata = s.opnd[1];
        mexp_pkg::MEXP_REG_OPND2: n.rdata = s.opnd[2];
        mexp_pkg::MEXP_REG_OPND3: n.rdata = s.opnd[3];
        mexp_pkg::MEXP_REG_RESULT: n.rdata = 32'(s.result);
        mexp_pkg::MEXP_REG_FLAGS: begin
          n.rdata = '0;
          n.rdata[mexp_pkg::MEXP_FLAG_DZ] = s.div_zero;
          n.rdata[mexp_pkg::MEXP_FLAG_OF] = s.overflow;
          n.rdata[mexp_pkg::MEXP_FLAG_ERR] = s.error_out;
          n.rdata[mexp_pkg::MEXP_FLAG_BUSY] = s.fsm != mexp_pkg::MEXP_ST_IDLE;
          n.rdata[mexp_pkg::MEXP_FLAG_UACT] = s.unit_active;
          n.rdata[mexp_pkg::MEXP_FLAG_DACT] = s.det_active;
        end
        mexp_pkg::MEXP_REG_IRQ_STAT: n.rdata = 32'(s.irq_stat);
        mexp_pkg::MEXP_REG_IRQ_MASK: n.rdata = 32'(s.irq_mask);
        default: n.rdata = '0;
      endcase
    end
    if (accept && req.write) begin
      unique case (req.addr)
        mexp_pkg::MEXP_REG_CTRL: begin
          // [RULE_17] Decimal places stored only
          wv = merge(32'(s.ctrl), req.wdata, req.be);
          n.ctrl = wv[mexp_pkg::MEXP_CTRL_W-1:0];
        end
        mexp_pkg::MEXP_REG_OPS: begin
          wv = merge(32'(s.opcfg), req.wdata, req.be);
          n.opcfg = wv[mexp_pkg::MEXP_OPCFG_W-1:0];
        end
        mexp_pkg::MEXP_REG_OPND0: n.opnd[0] = merge(s.opnd[0], req.wdata, req.be);
        mexp_pkg::MEXP_REG_OPND1: n.opnd[1] = merge(s.opnd[1], req.wdata, req.be);
        mexp_pkg::MEXP_REG_OPND2: n.opnd[2] = merge(s.opnd[2], req.wdata, req.be);
        mexp_pkg::MEXP_REG_OPND3: n.opnd[3] = merge(s.opnd[3], req.wdata, req.be);
        mexp_pkg::MEXP_REG_SCAN: scan_req = req.be[0] && req.wdata[mexp_pkg::MEXP_SCAN_GO];
        mexp_pkg::MEXP_REG_IRQ_STAT: n.irq_stat = s.irq_stat & ~req.wdata[mexp_pkg::MEXP_IRQ_W-1:0];
        mexp_pkg::MEXP_REG_IRQ_MASK: n.irq_mask = req.wdata[mexp_pkg::MEXP_IRQ_W-1:0];
        default: n.irq_stat = n.irq_stat;
      endcase
    end

    // [RULE_01] Unit armed by enable rising, disarmed by enable low
    n.en_q = s.ctrl.enable;
    if (s.ctrl.enable && !s.en_q) begin
      n.unit_active = 1'b1;
    end else if (!s.ctrl.enable) begin
      n.unit_active = 1'b0;
    end
    // [RULE_11] Detector armed by its own enable rising
    n.det_en_q = s.ctrl.det_en;
    if (s.ctrl.det_en && !s.det_en_q) begin
      n.det_active = 1'b1;
    end else if (!s.ctrl.det_en) begin
      n.det_active = 1'b0;
    end

    scan_go = scan_req && s.fsm == mexp_pkg::MEXP_ST_IDLE;
    unit_run = scan_go && s.unit_active;

    unique case (s.fsm)
      mexp_pkg::MEXP_ST_IDLE: begin
        if (unit_run) begin
          for (int i = 0; i < mexp_pkg::MEXP_NOPND; i++) begin
            n.vals[i] = widen(clamp16(s.opnd[i]));
          end
          n.cur = s.opcfg;
          n.step = '0;
          n.dz = 1'b0;
          n.ovp = 1'b0;
          n.ovn = 1'b0;
          n.fsm = mexp_pkg::MEXP_ST_EVAL;
        end
        // [RULE_15] Detector ahead of the unit sees last scan's flags
        if (scan_go && s.det_active && (!s.ctrl.det_after || !unit_run)) begin
          n.error_out = det_eval(s.error_out, s.ctrl, s.div_zero, s.overflow);
        end
      end
      mexp_pkg::MEXP_ST_EVAL: begin
        // [RULE_03] Three reductions over four values
        for (int i = 0; i < mexp_pkg::MEXP_NOPND - 1; i++) begin
          if (i == int'(pick)) begin
            n.vals[i] = op_y;
          end else if (i > int'(pick)) begin
            n.vals[i] = s.vals[i+1];
          end
        end
        for (int i = 0; i < mexp_pkg::MEXP_NOPER - 1; i++) begin
          if (i >= int'(pick)) begin
            n.cur.op[i] = s.cur.op[i+1];
            n.cur.pri[i] = s.cur.pri[i+1];
          end
        end
        n.dz = s.dz | op_dz;
        n.ovp = s.ovp | op_ovp;
        n.ovn = s.ovn | op_ovn;
        n.step = s.step + 2'h1;
        if (s.step == mexp_pkg::MEXP_STEP_LAST) begin
          n.fsm = mexp_pkg::MEXP_ST_DONE;
        end
      end
      mexp_pkg::MEXP_ST_DONE: begin
        // [RULE_06] Round half away from zero
        mag = s.vals[0][W-1] ? -s.vals[0] : s.vals[0];
        rq = (mag + mexp_pkg::MEXP_HALF) >> F;
        if (s.vals[0][W-1]) begin
          rq = -rq;
        end
        range_ovf = $signed(rq) > $signed(mexp_pkg::MEXP_WMAX16) || $signed(rq) < $signed(mexp_pkg::MEXP_WMIN16);
        if (s.ctrl.enable) begin
          // [RULE_02] Saturation on zero divide and overflow
          if (s.dz || s.ovp || (range_ovf && !rq[W-1])) begin
            n.result = mexp_pkg::MEXP_SAT_MAX;
          end else if (s.ovn || range_ovf) begin
            n.result = mexp_pkg::MEXP_SAT_MIN;
          end else begin
            n.result = rq[15:0];
          end
        end
        // [RULE_09] Flags rewritten every execution
        n.div_zero = s.dz;
        // Zero divide substitute value is not an overflow
        n.overflow = s.ovp | s.ovn | (range_ovf && !s.dz);
        ev[mexp_pkg::MEXP_IRQ_DONE] = 1'b1;
        // [RULE_15] Detector behind the unit sees this scan's flags
        if (s.det_active && s.ctrl.det_after) begin
          n.error_out = det_eval(s.error_out, s.ctrl, n.div_zero, n.overflow);
        end
        n.fsm = mexp_pkg::MEXP_ST_IDLE;
      end
    endcase

    // [RULE_07] Disabled output forced to zero unless holding
    if (!s.ctrl.enable && !s.ctrl.hold) begin
      n.result = '0;
    end
    // [RULE_12] Detector reset and missing reference clear output
    // [RULE_16] Missing reference keeps the output low
    if (s.ctrl.det_rst || !s.ctrl.ref_valid) begin
      n.error_out = 1'b0;
    end

    // Sticky status, set wins over a same-cycle clear
    ev[mexp_pkg::MEXP_IRQ_ERR] = n.error_out && !s.error_out;
    n.irq_stat = n.irq_stat | ev;
    n.irq = |(n.irq_stat & n.irq_mask);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s <= '0;
      s.fsm <= mexp_pkg::MEXP_ST_IDLE;
      s.waitreq <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign avs_readdata = s.rdata;
  assign avs_waitrequest = s.waitreq;
  assign result_out = s.result;
  assign div_zero_flag = s.div_zero;
  assign overflow_flag = s.overflow;
  assign error_out = s.error_out;
  assign irq = s.irq;

  a_unit_arm: assert property (@(posedge clk) disable iff (!resetn) // [RULE_01]
    $rose(s.unit_active) |-> $past(s.ctrl.enable) && !$past(s.en_q))
    else $error("unit armed without enable rising");
  a_div_zero_sat: assert property (@(posedge clk) disable iff (!resetn) // [RULE_02]
    (s.fsm == mexp_pkg::MEXP_ST_DONE && s.dz && s.ctrl.enable)
      |=> result_out == mexp_pkg::MEXP_SAT_MAX && div_zero_flag)
    else $error("zero divide did not saturate high");
  a_eval_length: assert property (@(posedge clk) disable iff (!resetn) // [RULE_03]
    (s.fsm == mexp_pkg::MEXP_ST_IDLE ##1 s.fsm == mexp_pkg::MEXP_ST_EVAL)
      |-> (s.fsm == mexp_pkg::MEXP_ST_EVAL) [*3] ##1 s.fsm == mexp_pkg::MEXP_ST_DONE ##1 s.fsm == mexp_pkg::MEXP_ST_IDLE)
    else $error("evaluation did not take three steps");
  a_result_range: assert property (@(posedge clk) disable iff (!resetn) // [RULE_02]
    (s.fsm == mexp_pkg::MEXP_ST_DONE && s.ctrl.enable && !s.dz && !s.ovp && !s.ovn)
      |=> !overflow_flag || result_out == mexp_pkg::MEXP_SAT_MAX || result_out == mexp_pkg::MEXP_SAT_MIN)
    else $error("overflow flag disagrees with result");
  a_disable_zero: assert property (@(posedge clk) disable iff (!resetn) // [RULE_07]
    (!s.ctrl.enable && !s.ctrl.hold) |=> result_out == 16'h0000)
    else $error("disabled result not zero");
  a_disable_hold: assert property (@(posedge clk) disable iff (!resetn) // [RULE_07]
    (!s.ctrl.enable && s.ctrl.hold && !$past(s.ctrl.enable)) |=> $stable(result_out))
    else $error("held result changed while disabled");
  a_flags_update: assert property (@(posedge clk) disable iff (!resetn) // [RULE_09]
    s.fsm == mexp_pkg::MEXP_ST_DONE |=> div_zero_flag == $past(s.dz) && (overflow_flag || !$past(s.ovp | s.ovn)))
    else $error("flags not updated at end of execution");
  a_det_reset: assert property (@(posedge clk) disable iff (!resetn) // [RULE_12]
    s.ctrl.det_rst |=> !error_out)
    else $error("detector reset did not clear output");
  a_err_latch: assert property (@(posedge clk) disable iff (!resetn) // [RULE_14]
    (error_out && !s.ctrl.auto_clear && !s.ctrl.det_rst && s.ctrl.ref_valid) |=> error_out)
    else $error("latched error dropped");
  a_null_ref: assert property (@(posedge clk) disable iff (!resetn) // [RULE_16]
    !s.ctrl.ref_valid |=> !error_out)
    else $error("error set without referenced unit");
  a_bus_accept: assert property (@(posedge clk) disable iff (!resetn)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus accept not one cycle");
endmodule

/* mexp_host.sv */
// Avalon-MM master model standing for the program that feeds the unit
`timescale 1ns/1ps
module mexp_host (
  input wire logic clk, // Bus clock
  output logic [mexp_pkg::MEXP_ADDR_W-1:0] avs_address, // Byte address
  output logic avs_read, // Read request
  output logic avs_write, // Write request
  output logic [31:0] avs_writedata, // Write data
  output logic [3:0] avs_byteenable, // Write byte lanes
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic avs_waitrequest // Stall from the slave
);
  initial begin
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'hf;
  end

  // Returns at the accept edge; released lines show the inverse of the last value
  task automatic xfer(input logic wr, input logic [mexp_pkg::MEXP_ADDR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    avs_address <= ~a;
    avs_writedata <= ~d;
  endtask
endmodule

/* test_mexp_unit.sv */
// Self-checking bench for the math expression unit and its error detector
`timescale 1ns/1ps
module test_mexp_unit;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [mexp_pkg::MEXP_ADDR_W-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] result_out;
  logic div_zero_flag;
  logic overflow_flag;
  logic error_out;
  logic irq;
  logic [31:0] rd;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;

  always #12.5 clk = ~clk;

  mexp_host i_host (.clk, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
                    .avs_readdata, .avs_waitrequest);

  mexp_unit i_dut (.clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
                   .avs_readdata, .avs_waitrequest, .result_out, .div_zero_flag, .overflow_flag,
                   .error_out, .irq);

  task automatic finish_test;
    if (failures == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, rd);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    i_host.xfer(1'b0, a, 32'h0000_0000, rd);
    check(rd, e);
  endtask

  task automatic scan;
    wr(mexp_pkg::MEXP_REG_SCAN, 32'h0000_0001);
    do begin
      i_host.xfer(1'b0, mexp_pkg::MEXP_REG_FLAGS, 32'h0000_0000, rd);
    end while (rd[mexp_pkg::MEXP_FLAG_BUSY] !== 1'b0);
  endtask

  // Operands listed first to fourth; fl is overflow then divide-by-zero
  task automatic expr(input logic [31:0] ops, input logic [3:0][31:0] v, input logic [15:0] r,
                      input logic [1:0] fl);
    wr(mexp_pkg::MEXP_REG_OPS, ops);
    for (int i = 0; i < 4; i++) begin
      wr(mexp_pkg::MEXP_REG_OPND0 + 8'(4 * i), v[3 - i]);
    end
    scan();
    check(result_out, r);
    check({overflow_flag, div_zero_flag}, fl);
    rdchk(mexp_pkg::MEXP_REG_RESULT, {16'h0000, r});
  endtask

  // Canned cases: clean sum, zero divide, positive overflow
  task automatic run(input logic [1:0] k);
    case (k)
      2'h0: expr(32'h0000_0000, {32'h0000_0001, 32'h0000_0002, 32'h0000_0003, 32'h0000_0004}, 16'h000a, 2'b00);
      2'h1: expr(32'h0000_0003, {32'h0000_0005, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000}, 16'h7fff, 2'b01);
      default: expr(32'h0000_0002, {32'h0000_012c, 32'h0000_012c, 32'h0000_0000, 32'h0000_0000}, 16'h7fff, 2'b10);
    endcase
  endtask

  task automatic det(input logic [31:0] ctl, input logic [1:0] k, input logic e);
    wr(mexp_pkg::MEXP_REG_CTRL, ctl);
    run(k);
    check(error_out, e);
  endtask

  task automatic t_reset;
    check({result_out, div_zero_flag, overflow_flag, error_out, irq, avs_waitrequest}, 32'h0000_0001);
    rdchk(mexp_pkg::MEXP_REG_CTRL, 32'h0000_0000);
    wr(8'h3c, 32'hffff_ffff);
    rdchk(8'h3c, 32'h0000_0000);
    wr(mexp_pkg::MEXP_REG_RESULT, 32'h0000_1234);
    rdchk(mexp_pkg::MEXP_REG_RESULT, 32'h0000_0000);
  endtask

  task automatic t_arith;
    wr(mexp_pkg::MEXP_REG_CTRL, 32'h0000_0301);
    expr(32'h0000_025c, {32'h0000_000c, 32'h0000_0006, 32'h0000_0003, 32'h0000_0001}, 16'h000d, 2'b00);
    expr(32'h0000_048d, {32'h0000_0064, 32'h0000_0019, 32'h0000_0002, 32'h0000_0001}, 16'h0019, 2'b00);
    expr(32'h0000_000b, {32'h0000_0007, 32'h0000_0002, 32'h0000_0001, 32'h0000_0000}, 16'h0004, 2'b00);
    expr(32'h0000_000b, {32'hffff_fff9, 32'h0000_0002, 32'h0000_0001, 32'h0000_0000}, 16'hfffc, 2'b00);
    expr(32'h0000_000e, {32'h0000_012c, 32'h0000_012c, 32'h0000_000a, 32'h0000_0000}, 16'h2328, 2'b00);
    run(2'h2);
    expr(32'h0000_0002, {32'hffff_fed4, 32'h0000_012c, 32'h0000_0000, 32'h0000_0000}, 16'h8000, 2'b10);
    expr(32'h0000_0000, {32'h0001_86a0, 32'hffff_ffff, 32'h0000_0000, 32'h0000_0000}, 16'h7ffe, 2'b00);
    expr(32'h0000_0001, {32'hfffe_7960, 32'hffff_ffff, 32'h0000_0000, 32'h0000_0000}, 16'h8001, 2'b00);
    run(2'h1);
  endtask

  task automatic t_enable;
    wr(mexp_pkg::MEXP_REG_CTRL, 32'h0000_0002);
    rdchk(mexp_pkg::MEXP_REG_FLAGS, 32'h0000_0001);
    check(result_out, 16'h7fff);
    wr(mexp_pkg::MEXP_REG_OPS, 32'h0000_0000);
    scan();
    check({result_out, overflow_flag, div_zero_flag}, {16'h7fff, 2'b01});
    wr(mexp_pkg::MEXP_REG_CTRL, 32'h0000_0000);
    rdchk(mexp_pkg::MEXP_REG_RESULT, 32'h0000_0000);
    check(result_out, 16'h0000);
    wr(mexp_pkg::MEXP_REG_CTRL, 32'h0000_0001);
    i_host.xfer(1'b0, mexp_pkg::MEXP_REG_FLAGS, 32'h0000_0000, rd);
    check(rd[mexp_pkg::MEXP_FLAG_UACT], 1'b1);
    run(2'h0);
  endtask

  task automatic t_detect;
    det(32'h0000_00c9, 2'h1, 1'b0);
    det(32'h0000_00cd, 2'h1, 1'b1);
    det(32'h0000_00cd, 2'h0, 1'b0);
    det(32'h0000_00dd, 2'h1, 1'b0);
    det(32'h0000_00dd, 2'h2, 1'b1);
    det(32'h0000_00e5, 2'h1, 1'b1);
    det(32'h0000_00e5, 2'h0, 1'b1);
    wr(mexp_pkg::MEXP_REG_CTRL, 32'h0000_04e5);
    rdchk(mexp_pkg::MEXP_REG_FLAGS, 32'h0000_0030);
    check(error_out, 1'b0);
    det(32'h0000_00e5, 2'h0, 1'b0);
    det(32'h0000_004d, 2'h1, 1'b0);
    det(32'h0000_004d, 2'h0, 1'b1);
    det(32'h0000_008d, 2'h1, 1'b0);
  endtask

  task automatic t_irq;
    wr(mexp_pkg::MEXP_REG_IRQ_STAT, 32'h0000_0003);
    rdchk(mexp_pkg::MEXP_REG_IRQ_STAT, 32'h0000_0000);
    wr(mexp_pkg::MEXP_REG_IRQ_MASK, 32'h0000_0001);
    rdchk(mexp_pkg::MEXP_REG_IRQ_MASK, 32'h0000_0001);
    run(2'h0);
    rdchk(mexp_pkg::MEXP_REG_IRQ_STAT, 32'h0000_0001);
    check(irq, 1'b1);
    wr(mexp_pkg::MEXP_REG_IRQ_STAT, 32'h0000_0001);
    rdchk(mexp_pkg::MEXP_REG_IRQ_STAT, 32'h0000_0000);
    check(irq, 1'b0);
    wr(mexp_pkg::MEXP_REG_IRQ_MASK, 32'h0000_0000);
    run(2'h0);
    check(irq, 1'b0);
    det(32'h0000_00cd, 2'h1, 1'b1);
    rdchk(mexp_pkg::MEXP_REG_IRQ_STAT, 32'h0000_0003);
    check(irq, 1'b0);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_arith();
    t_enable();
    t_detect();
    t_irq();
    finish_test();
  end
endmodule
